//--- design/ure_top.sv
// Receive error status and receive timeout block of a UART, APB slave.
// Assumes one 25 MHz clock; rxd_i is asynchronous to it.
//
// How it works
// - Stop bit sampled low sets the framing fault bit 0.
// - Parity mismatch against line control bits 2 and 7 sets bit 1.
// - Line low over a whole character time sets the break bit 2.
// - A break loads exactly one zero character into the FIFO.
// - After a break, wait for marking line then a valid start bit.
// - Character finishing with the FIFO full sets overrun bit 3.
// - On overrun FIFO entries stay untouched; nothing is written.
// - Any write to the error clear register clears all four flags, except an overrun or a new head into an empty FIFO in the same cycle.
// - With FIFO on, flags describe the character at the FIFO head.
// - Timeout period is 22 bits read-write, reset 0x1FF.
// - Timeout interrupt when FIFO holds data and nothing new arrives.
// - Period counts oversample ticks: sixteen or eight per bit.
`timescale 1ns/100ps
`default_nettype none
module ure_top #(
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        reset_n_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Serial line and interrupt
  input  wire logic        rxd_i,
  output logic             irq_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int EW = 11;

  typedef struct packed {
    logic                               pready;
    logic [31:0]                        prdata;
    logic                               pslverr;
    logic                               took;
    logic [DEPTH-1:0][EW-1:0]           mem;
    logic [AW-1:0]                      wptr;
    logic [AW-1:0]                      rptr;
    logic [AW:0]                        cnt;
    logic                               hide;
    logic                               ovr;
    logic [ure_pkg::TOUT_W-1:0]         period;
    logic [ure_pkg::DIV_W-1:0]          div;
    logic [ure_pkg::DIV_W-1:0]          dcnt;
    logic                               tick;
    logic [7:0]                         line;
    logic [7:0]                         ctrl;
    logic [ure_pkg::IRQ_W-1:0]          mask;
    logic [ure_pkg::IRQ_W-1:0]          ists;
    logic [ure_pkg::TOUT_W-1:0]         tcnt;
    logic                               irq;
  } ure_top_t;
  ure_top_t r_q, r_d;

  ure_char_if ch ();

  logic           done;
  logic           wr;
  logic           rd;
  logic           full;
  logic           empty;
  logic           push;
  logic           pop;
  logic [3:0]     err_now;
  logic [31:0]    rdata;
  logic           hit;
  logic [EW-1:0]  head;

  ////////////////////////////////////////////////////////////////////
  // Line sampler
  ure_sampler u_smp (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .rxd_i     (rxd_i),
    .ch        (ch)
  );

  // Configuration towards the sampler
  assign ch.tick      = r_q.tick;
  assign ch.ovs8      = r_q.ctrl[ure_pkg::CTRL_OVS];
  assign ch.par_en    = r_q.line[ure_pkg::LINE_PEN];
  assign ch.par_even  = r_q.line[ure_pkg::LINE_EVEN];
  assign ch.par_stick = r_q.line[ure_pkg::LINE_STICK];

  ////////////////////////////////////////////////////////////////////
  // Bus phase and FIFO status
  assign done  = psel_i && penable_i && r_q.pready;
  assign wr    = done && pwrite_i;
  assign rd    = done && !pwrite_i;
  assign empty = r_q.cnt == '0;
  // Without the FIFO only a single holding entry is used
  assign full  = r_q.ctrl[ure_pkg::CTRL_FEN] ?
                 (r_q.cnt == (AW+1)'(DEPTH)) : !empty;
  assign push  = ch.valid && !full;
  // Pop only an entry the read has shown; a late arrival stays queued
  assign pop   = rd && (paddr_i == ure_pkg::OFF_DATA) && r_q.took;
  assign head  = r_q.mem[r_q.rptr];

  // Error status: head entry flags, hidden after a clear
  always_comb begin
    err_now                   = '0;
    if (!empty && !r_q.hide) begin
      err_now[ure_pkg::ERR_BRK:ure_pkg::ERR_FRAME] = head[10:8];
    end
    err_now[ure_pkg::ERR_OVR] = r_q.ovr;
  end

  ////////////////////////////////////////////////////////////////////
  // Read data decode
  always_comb begin
    rdata = '0;
    hit   = 1'b1;
    if (paddr_i == ure_pkg::OFF_DATA) begin
      rdata[EW-1:0]                          = empty ? '0 : head;
      rdata[ure_pkg::DATA_ERR+ure_pkg::ERR_OVR] = r_q.ovr;
    end else if (paddr_i == ure_pkg::OFF_ERR) begin
      rdata[3:0] = err_now;
    end else if (paddr_i == ure_pkg::OFF_TOUT) begin
      rdata[ure_pkg::TOUT_W-1:0] = r_q.period;
    end else if (paddr_i == ure_pkg::OFF_FLAG) begin
      rdata[ure_pkg::FLAG_EMPTY] = empty;
      rdata[ure_pkg::FLAG_FULL]  = full;
    end else if (paddr_i == ure_pkg::OFF_LINE) begin
      rdata[7:0] = r_q.line;
    end else if (paddr_i == ure_pkg::OFF_DIV) begin
      rdata[ure_pkg::DIV_W-1:0] = r_q.div;
    end else if (paddr_i == ure_pkg::OFF_CTRL) begin
      rdata[7:0] = r_q.ctrl;
    end else if (paddr_i == ure_pkg::OFF_MASK) begin
      rdata[ure_pkg::IRQ_W-1:0] = r_q.mask;
    end else if (paddr_i == ure_pkg::OFF_IRQ) begin
      rdata[ure_pkg::IRQ_W-1:0] = r_q.ists;
    end else begin
      hit = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    r_d = r_q;
    // One wait cycle: answer in the cycle after the access phase starts
    r_d.pready  = psel_i && penable_i && !r_q.pready;
    if (psel_i && penable_i && !r_q.pready) begin
      r_d.prdata  = pwrite_i ? '0 : rdata;
      r_d.pslverr = !hit;
      r_d.took    = !empty;                                        // Head shown
    end
    // Oversample tick divider
    r_d.tick = 1'b0;
    if (r_q.dcnt >= r_q.div) begin
      r_d.dcnt = '0;
      r_d.tick = 1'b1;
    end else begin
      r_d.dcnt = ure_pkg::DIV_W'(r_q.dcnt + 1'b1);
    end
    // Register writes
    if (wr) begin
      if (paddr_i == ure_pkg::OFF_ERR) begin
        r_d.hide = 1'b1;
        r_d.ovr  = 1'b0;
      end else if (paddr_i == ure_pkg::OFF_TOUT) begin
        r_d.period = pwdata_i[ure_pkg::TOUT_W-1:0];
      end else if (paddr_i == ure_pkg::OFF_LINE) begin
        r_d.line = pwdata_i[7:0];
      end else if (paddr_i == ure_pkg::OFF_DIV) begin
        r_d.div = pwdata_i[ure_pkg::DIV_W-1:0];
      end else if (paddr_i == ure_pkg::OFF_CTRL) begin
        r_d.ctrl = pwdata_i[7:0];
      end else if (paddr_i == ure_pkg::OFF_MASK) begin
        r_d.mask = pwdata_i[ure_pkg::IRQ_W-1:0];
      end
    end
    // Read of interrupt status clears it
    if (rd && paddr_i == ure_pkg::OFF_IRQ) begin
      r_d.ists = '0;
    end
    // FIFO write; full drops the character, entries kept
    if (push) begin
      r_d.mem[r_q.wptr] = {ch.be, ch.pe, ch.fe, ch.data};
      r_d.wptr          = AW'(r_q.wptr + 1'b1);
    end
    if (pop) begin
      r_d.rptr = AW'(r_q.rptr + 1'b1);
      r_d.hide = 1'b0;
    end
    // A fresh head after an empty FIFO shows its own flags; beats a clear
    if (push && empty) begin
      r_d.hide = 1'b0;
    end
    r_d.cnt = (AW+1)'(r_q.cnt + push - pop);
    // Overrun: set wins over clear
    if (ch.valid && full) begin
      r_d.ovr                  = 1'b1;
      r_d.ists[ure_pkg::IRQ_OVR] = 1'b1;
    end
    if (ch.valid && (ch.fe || ch.pe || ch.be)) begin
      r_d.ists[ure_pkg::IRQ_ERR] = 1'b1;
    end
    // Receive timeout counted in oversample ticks
    if (ch.valid || empty) begin
      r_d.tcnt = '0;
    end else if (r_q.tick && r_q.tcnt < r_q.period) begin
      r_d.tcnt = ure_pkg::TOUT_W'(r_q.tcnt + 1'b1);
      if (r_d.tcnt == r_q.period) begin
        r_d.ists[ure_pkg::IRQ_TOUT] = 1'b1;
      end
    end
    r_d.irq = |(r_d.ists & r_q.mask);
  end

  ////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      r_q        <= '0;
      r_q.period <= ure_pkg::TOUT_RST;
      r_q.div    <= ure_pkg::DIV_RST;
      r_q.line   <= ure_pkg::LINE_RST;
      r_q.ctrl   <= ure_pkg::CTRL_RST;
    end else begin
      r_q <= r_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs
  assign prdata_o  = r_q.prdata;
  assign pready_o  = r_q.pready;
  assign pslverr_o = r_q.pslverr;
  assign irq_o     = r_q.irq;

  ////////////////////////////////////////////////////////////////////
  // Checks
  chk_ecr_clear: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    wr && paddr_i == ure_pkg::OFF_ERR && !ch.valid |=> !r_q.ovr && r_q.hide)
    else $error("Error clear write left flags set");
  chk_overrun_set: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    ch.valid && full |=> r_q.ovr)
    else $error("Overrun not flagged");
  chk_overrun_keep: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    ch.valid && full |=> r_q.wptr == $past(r_q.wptr) && r_q.mem == $past(r_q.mem))
    else $error("FIFO changed on overrun");
  chk_head_flags: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    push && empty |=> err_now[2:0] == $past({ch.be, ch.pe, ch.fe}))
    else $error("Error flags not from FIFO head");
  chk_period_reset: assert property (@(posedge clk_sys_i)
    $rose(reset_n_i) |-> r_q.period == ure_pkg::TOUT_RST)
    else $error("Timeout period reset value wrong");
  chk_tout_restart: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    ch.valid || empty |=> r_q.tcnt == '0)
    else $error("Timeout count not restarted");
  chk_tout_fire: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    r_q.tick && !ch.valid && !empty && r_q.tcnt == ure_pkg::TOUT_W'(r_q.period - 1'b1)
    && r_q.period != '0 |=> r_q.ists[ure_pkg::IRQ_TOUT])
    else $error("Timeout interrupt missing");
  chk_irq_level: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    ##1 irq_o == |($past(r_d.ists) & $past(r_q.mask)))
    else $error("Interrupt output does not follow status");

  // Handshake and FIFO bookkeeping
  chk_ready_pulse: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    r_q.pready |=> !r_q.pready)
    else $error("Ready held longer than one cycle");
  chk_fifo_bound: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    r_q.cnt <= (AW+1)'(DEPTH))
    else $error("FIFO count beyond depth");
  chk_head_keep: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    push && !empty && !pop && !wr |=> err_now[2:0] == $past(err_now[2:0]))
    else $error("Newer character changed head flags");

  // Error and interrupt flags
  chk_ovr_hold: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    r_q.ovr && !(wr && paddr_i == ure_pkg::OFF_ERR) |=> r_q.ovr)
    else $error("Overrun dropped without a clear");
  chk_irq_clear: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    rd && paddr_i == ure_pkg::OFF_IRQ && !ch.valid && !r_q.tick |=> r_q.ists == '0)
    else $error("Interrupt status not cleared by read");

  // Timeout counter and tick divider
  chk_period_write: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    wr && paddr_i == ure_pkg::OFF_TOUT |=> r_q.period == $past(pwdata_i[ure_pkg::TOUT_W-1:0]))
    else $error("Timeout period write lost");
  chk_tick_gap: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    r_q.tick && r_q.div != '0 |=> !r_q.tick)
    else $error("Oversample ticks too close");
  chk_tout_ticks: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    !r_q.tick && !ch.valid && !empty |=> r_q.tcnt == $past(r_q.tcnt))
    else $error("Timeout count moved without a tick");
  chk_tout_hold: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    r_q.tcnt == r_q.period && !ch.valid && !empty |=> r_q.tcnt == $past(r_q.tcnt))
    else $error("Timeout count ran past the period");
endmodule // ure_top
`default_nettype wire

//--- inc/ure_pkg.sv
// Constants shared by the receive error and timeout block.
// Assumes a 32-bit APB register bus and an 8-bit character.
package ure_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_DATA  = 8'h00;
  localparam logic [7:0] OFF_ERR   = 8'h04;
  localparam logic [7:0] OFF_TOUT  = 8'h0c;
  localparam logic [7:0] OFF_FLAG  = 8'h18;
  localparam logic [7:0] OFF_LINE  = 8'h1c;
  localparam logic [7:0] OFF_DIV   = 8'h24;
  localparam logic [7:0] OFF_CTRL  = 8'h30;
  localparam logic [7:0] OFF_MASK  = 8'h38;
  localparam logic [7:0] OFF_IRQ   = 8'h3c;
  // Error field positions (status register, data word high byte)
  localparam int ERR_FRAME = 0;
  localparam int ERR_PAR   = 1;
  localparam int ERR_BRK   = 2;
  localparam int ERR_OVR   = 3;
  localparam int DATA_ERR  = 8;
  // Line control bits
  localparam int LINE_PEN   = 1;
  localparam int LINE_EVEN  = 2;
  localparam int LINE_STICK = 7;
  // Control bits
  localparam int CTRL_OVS = 0;
  localparam int CTRL_FEN = 4;
  // Flag bits
  localparam int FLAG_EMPTY = 4;
  localparam int FLAG_FULL  = 6;
  // Interrupt bits
  localparam int IRQ_TOUT = 0;
  localparam int IRQ_ERR  = 1;
  localparam int IRQ_OVR  = 2;
  localparam int IRQ_W    = 3;
  // Widths and reset values
  localparam int TOUT_W = 22;
  localparam int DIV_W  = 16;
  localparam logic [TOUT_W-1:0] TOUT_RST = 22'h00_01ff;
  localparam logic [DIV_W-1:0]  DIV_RST  = 16'h000d;
  localparam logic [7:0]        LINE_RST = 8'h00;
  localparam logic [7:0]        CTRL_RST = 8'h10;
  // Oversampling factors
  localparam logic [4:0] OVS_16 = 5'h10;
  localparam logic [4:0] OVS_8  = 5'h08;
  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BRK
  } ure_rx_st_t;
endpackage

//--- inc/ure_char_if.sv
// Link between the line sampler and the register side.
// Assumes one clock; tick is a one-cycle oversample enable.
`timescale 1ns/100ps
`default_nettype none
interface ure_char_if;
  logic       tick;
  logic       ovs8;
  logic       par_en;
  logic       par_even;
  logic       par_stick;
  logic       valid;
  logic [7:0] data;
  logic       fe;
  logic       pe;
  logic       be;
  modport rcv (input tick, ovs8, par_en, par_even, par_stick,
               output valid, data, fe, pe, be);
  modport top (output tick, ovs8, par_en, par_even, par_stick,
               input valid, data, fe, pe, be);
endinterface
`default_nettype wire

//--- design/ure_sampler.sv
// Serial line sampler: frames one 8-bit character with optional parity.
// Assumes rxd_i is asynchronous and tick comes from the top divider.
`timescale 1ns/100ps
`default_nettype none
module ure_sampler (
  // Clock and reset
  input  wire logic    clk_sys_i,
  input  wire logic    reset_n_i,
  // Serial line
  input  wire logic    rxd_i,
  // Character link
  ure_char_if.rcv      ch
);
  typedef struct packed {
    logic                s1;
    logic                s2;
    ure_pkg::ure_rx_st_t st;
    logic [4:0]          cnt;
    logic [2:0]          bitn;
    logic [7:0]          sh;
    logic                pbit;
    logic                valid;
    logic                fe;
    logic                pe;
    logic                be;
  } ure_smp_t;
  ure_smp_t s_q, s_d;
  logic [4:0] full_bit;
  logic [4:0] half_bit;
  logic       at_mid;
  logic       exp_par;

  ////////////////////////////////////////////////////////////////////
  // Bit timing and expected parity
  assign full_bit = ch.ovs8 ? ure_pkg::OVS_8 : ure_pkg::OVS_16;
  assign half_bit = {1'b0, full_bit[4:1]};
  assign at_mid   = ch.tick && (s_q.cnt == 5'((s_q.st == ure_pkg::RX_START ?
                    half_bit : full_bit) - 5'h01));
  assign exp_par  = ch.par_stick ? ~ch.par_even :
                    (ch.par_even ? ^s_q.sh : ~^s_q.sh);

  ////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_d       = s_q;
    s_d.s1    = rxd_i;
    s_d.s2    = s_q.s1;
    s_d.valid = 1'b0;
    if (ch.tick) begin
      s_d.cnt = 5'(s_q.cnt + 5'h01);
    end
    if (at_mid) begin
      s_d.cnt = 5'h00;
    end
    case (s_q.st)
      ure_pkg::RX_IDLE: begin
        s_d.cnt = 5'h00;
        if (!s_q.s2) begin
          s_d.st = ure_pkg::RX_START;
        end
      end
      ure_pkg::RX_START: begin
        if (at_mid) begin
          s_d.st   = s_q.s2 ? ure_pkg::RX_IDLE : ure_pkg::RX_DATA;
          s_d.bitn = 3'h0;
        end
      end
      ure_pkg::RX_DATA: begin
        if (at_mid) begin
          s_d.sh   = {s_q.s2, s_q.sh[7:1]};
          s_d.bitn = 3'(s_q.bitn + 3'h1);
          if (s_q.bitn == 3'h7) begin
            s_d.st = ch.par_en ? ure_pkg::RX_PAR : ure_pkg::RX_STOP;
          end
        end
      end
      ure_pkg::RX_PAR: begin
        if (at_mid) begin
          s_d.pbit = s_q.s2;
          s_d.pe   = s_q.s2 != exp_par;
          s_d.st   = ure_pkg::RX_STOP;
        end
      end
      ure_pkg::RX_STOP: begin
        if (at_mid) begin
          s_d.valid = 1'b1;
          s_d.fe    = !s_q.s2;
          // Whole character time low: one zero character, then wait
          s_d.be    = !s_q.s2 && (s_q.sh == 8'h00) &&
                      !(ch.par_en && s_q.pbit);
          if (!ch.par_en) begin
            s_d.pe = 1'b0;
          end
          if (s_d.be) begin
            s_d.pe = 1'b0;
            s_d.st = ure_pkg::RX_BRK;
          end else begin
            s_d.st = ure_pkg::RX_IDLE;
          end
        end
      end
      ure_pkg::RX_BRK: begin
        // Line must mark again before a new start bit counts
        if (s_q.s2) begin
          s_d.st = ure_pkg::RX_IDLE;
        end
      end
      default: s_d.st = ure_pkg::RX_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      s_q    <= '0;
      s_q.s1 <= 1'b1;
      s_q.s2 <= 1'b1;
      s_q.st <= ure_pkg::RX_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Character outputs
  assign ch.valid = s_q.valid;
  assign ch.data  = s_q.sh;
  assign ch.fe    = s_q.fe;
  assign ch.pe    = s_q.pe;
  assign ch.be    = s_q.be;

  ////////////////////////////////////////////////////////////////////
  // Checks
  chk_break_zero: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    s_q.valid && s_q.be |-> s_q.sh == 8'h00 && s_q.st == ure_pkg::RX_BRK)
    else $error("Break did not give one zero character");
  chk_break_mark: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    s_q.st == ure_pkg::RX_BRK && !s_q.s2 |=> s_q.st == ure_pkg::RX_BRK)
    else $error("Left break wait while line still low");
endmodule // ure_sampler
`default_nettype wire

//--- testbench/ure_line_model.sv
// Remote serial transmitter model driving the receive line.
// Assumes callers enter its tasks right after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module ure_line_model (
  // Clock
  input  wire logic clk_sys_i,
  // Serial line
  output var logic  rxd_o
);
  // Line idles marking high
  initial rxd_o = 1'b1;

  // One bit level held for a whole bit time
  task automatic put(input logic b, input int clks);
    rxd_o <= b;
    repeat (clks) @(posedge clk_sys_i);
  endtask

  // Start, data LSB first, optional parity, stop, then one idle bit
  task automatic send(input logic [7:0] d, input logic pen, input logic par,
                      input logic stop, input int clks);
    put(1'b0, clks);
    for (int i = 0; i < 8; i++) put(d[i], clks);
    if (pen) put(par, clks);
    put(stop, clks);
    put(1'b1, clks);
  endtask

  // Line held low for a long spell, then back to marking
  task automatic hold_low(input int clks);
    put(1'b0, clks);
    put(1'b1, 64);
  endtask
endmodule // ure_line_model
`default_nettype wire

//--- testbench/tb_uart_rx_error_and_timeout.sv
// Self-checking bench for the receive error and timeout block.
// Assumes ure_pkg, the design files and the line model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_uart_rx_error_and_timeout;
  // Clock, reset and bus drive
  logic        clk_sys_i;
  logic        reset_n_i;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rxd;
  logic        irq;
  logic [31:0] rdv;
  logic        erv;
  int          err_total;
  int          samples_checked;
  int          bclk;

  ure_top #(.DEPTH(16)) ure_top_i (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .rxd_i(rxd), .irq_o(irq));
  ure_line_model ure_line_model_i (.clk_sys_i(clk_sys_i), .rxd_o(rxd));

  // 25 MHz clock
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Verdict, comparison and bus tasks
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) chk("pready", 32'h0000_0001, 32'h0000_0000);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, e, rdv & m);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: the whole run needs well under 15000 cycles
  initial begin
    repeat (40000) @(posedge clk_sys_i);
    chk("run length", 32'h0000_0000, 32'h0000_0001);
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin : main
    logic [7:0] lcr [4];
    logic [3:0] good;
    lcr = '{8'h02, 8'h06, 8'h86, 8'h82};
    good = {1'b1, 1'b0, ^8'h35, ~^8'h35};  // Odd, even, stick low, stick high
    err_total = 0;
    samples_checked = 0;
    reset_n_i = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (12) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    @(posedge clk_sys_i);
    // Reset values, field width, unmapped place
    rdc("timeout reset", ure_pkg::OFF_TOUT, 32'hffff_ffff, 32'h0000_01ff);
    rdc("status reset", ure_pkg::OFF_ERR, 32'hffff_ffff, 32'h0000_0000);
    wr(ure_pkg::OFF_TOUT, 32'hffff_ffff);
    rdc("timeout width", ure_pkg::OFF_TOUT, 32'hffff_ffff, 32'h003f_ffff);
    rdc("unmapped", 8'h80, 32'hffff_ffff, 32'h0000_0000);
    chk("slverr", 32'h0000_0001, {31'h0, erv});
    // Fast line: one tick per clock, x16
    wr(ure_pkg::OFF_DIV, 32'h0000_0000);
    bclk = 16;
    // Bad stop bit, then clear by a write of any value
    ure_line_model_i.send(8'h5a, 1'b0, 1'b0, 1'b0, bclk);
    rdc("frame flag", ure_pkg::OFF_ERR, 32'hffff_ffff, 32'h0000_0001);
    wr(ure_pkg::OFF_ERR, 32'h1234_5678);
    rdc("after clear", ure_pkg::OFF_ERR, 32'hffff_ffff, 32'h0000_0000);
    rdc("frame data", ure_pkg::OFF_DATA, 32'h0000_00ff, 32'h0000_005a);
    // Every parity mode: wrong then right, flags follow the head
    for (int i = 0; i < 4; i++) begin
      wr(ure_pkg::OFF_LINE, {24'h0, lcr[i]});
      ure_line_model_i.send(8'h35, 1'b1, ~good[i], 1'b1, bclk);
      ure_line_model_i.send(8'h35, 1'b1, good[i], 1'b1, bclk);
      rdc("parity flag", ure_pkg::OFF_ERR, 32'hffff_ffff, 32'h0000_0002);
      rdc("parity data", ure_pkg::OFF_DATA, 32'h0000_0fff, 32'h0000_0235);
      rdc("head flags", ure_pkg::OFF_ERR, 32'hffff_ffff, 32'h0000_0000);
      rdc("good data", ure_pkg::OFF_DATA, 32'h0000_0fff, 32'h0000_0035);
    end
    wr(ure_pkg::OFF_LINE, 32'h0000_0000);
    // Long break: one zero character, then a normal one
    ure_line_model_i.hold_low(30 * bclk);
    rdc("break flag", ure_pkg::OFF_ERR, 32'h0000_0004, 32'h0000_0004);
    rdc("break char", ure_pkg::OFF_DATA, 32'h0000_04ff, 32'h0000_0400);
    rdc("one char", ure_pkg::OFF_FLAG, 32'h0000_0010, 32'h0000_0010);
    ure_line_model_i.send(8'h3c, 1'b0, 1'b0, 1'b1, bclk);
    rdc("after break", ure_pkg::OFF_DATA, 32'h0000_00ff, 32'h0000_003c);
    // Fill the FIFO, one more overruns, drain intact
    for (int i = 0; i < 17; i++) begin
      ure_line_model_i.send(8'h40 + 8'(i), 1'b0, 1'b0, 1'b1, bclk);
    end
    rdc("overrun", ure_pkg::OFF_ERR, 32'h0000_0008, 32'h0000_0008);
    rdc("full", ure_pkg::OFF_FLAG, 32'h0000_0040, 32'h0000_0040);
    for (int i = 0; i < 16; i++) begin
      rdc("kept entry", ure_pkg::OFF_DATA, 32'h0000_00ff, 32'h40 + i);
    end
    rdc("drained", ure_pkg::OFF_FLAG, 32'h0000_0010, 32'h0000_0010);
    wr(ure_pkg::OFF_ERR, 32'h0000_0000);
    rdc("overrun clear", ure_pkg::OFF_ERR, 32'hffff_ffff, 32'h0000_0000);
    // Timeout: tick every 4 clocks, x8, 64 ticks = 256 clocks, masked first
    wr(ure_pkg::OFF_DIV, 32'h0000_0003);
    wr(ure_pkg::OFF_CTRL, 32'h0000_0011);
    wr(ure_pkg::OFF_TOUT, 32'h0000_0040);
    bclk = 32;
    ure_line_model_i.send(8'h77, 1'b0, 1'b0, 1'b1, bclk);
    repeat (150) @(posedge clk_sys_i);
    rdc("early timeout", ure_pkg::OFF_IRQ, 32'h0000_0001, 32'h0000_0000);
    repeat (180) @(posedge clk_sys_i);
    chk("masked irq", 32'h0000_0000, {31'h0, irq});
    wr(ure_pkg::OFF_MASK, 32'h0000_0001);
    // New mask reaches the registered output one edge after the write
    @(posedge clk_sys_i);
    chk("timeout irq", 32'h0000_0001, {31'h0, irq});
    rdc("timeout status", ure_pkg::OFF_IRQ, 32'h0000_0001, 32'h0000_0001);
    @(posedge clk_sys_i);
    chk("irq cleared", 32'h0000_0000, {31'h0, irq});
    rdc("timeout char", ure_pkg::OFF_DATA, 32'h0000_00ff, 32'h0000_0077);
    // Empty FIFO never times out
    repeat (400) @(posedge clk_sys_i);
    rdc("empty no timeout", ure_pkg::OFF_IRQ, 32'h0000_0001, 32'h0000_0000);
    report_and_stop();
  end
endmodule // tb_uart_rx_error_and_timeout
`default_nettype wire
